// ==== pkg/segment_map_pkg.sv ====
// Purpose: constants and carriers for the legacy segment attribute map
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: one attribute nibble per 16 Kbyte segment, system BIOS is 64 Kbyte
package segment_map_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned WB_ADR_W = 10;
  localparam int unsigned ATTR_COUNT = 7;

  // register indexes, byte address is four times these
  localparam logic [7:0] IDX_ATTR_FIRST = 8'h59;
  localparam logic [7:0] IDX_ATTR_LAST = 8'h5f;
  localparam logic [7:0] IDX_HOLE_CTRL = 8'h40;
  localparam logic [7:0] IDX_ROUTE_STATUS = 8'h41;
  localparam logic [7:0] ATTR_RESET = 8'h00;
  localparam logic [7:0] HOLE_CTRL_RESET = 8'h00;

  // nibble field positions
  localparam int unsigned BIT_READ_EN = 0;
  localparam int unsigned BIT_WRITE_EN = 1;
  localparam int unsigned BIT_CACHE_EN = 2;
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned HOLE_EN_BIT = 0;

  // address map, 16 Kbyte granule index is addr[19:14]
  localparam logic [ADDR_W-1:0] VIDEO_BASE = 32'h000a0000;
  localparam logic [ADDR_W-1:0] EXP_BASE = 32'h000c0000;
  localparam logic [ADDR_W-1:0] BIOS_BASE = 32'h000f0000;
  localparam logic [ADDR_W-1:0] EXT_BASE = 32'h00100000;
  localparam logic [5:0] GRANULE_EXP_FIRST = 6'h30;
  localparam int unsigned GRANULE_LSB = 14;

  // attribute triple returned by decode: {cache, write, read}
  localparam logic [2:0] ATTR_ALL = 3'h7;
  localparam logic [2:0] ATTR_NONE = 3'h0;

  typedef struct packed {
    logic valid;
    logic write;
    logic code;
    logic [ADDR_W-1:0] addr;
  } host_req_s;

  typedef struct packed {
    logic valid;
    logic to_memory;
    logic to_pci;
    logic l1_cacheable;
    logic l2_allocate;
  } host_route_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } pci_req_s;

  typedef struct packed {
    logic valid;
    logic claim;
  } pci_ans_s;

endpackage

// ==== design/segment_attribute_map.sv ====
// Purpose: per-segment read, write and cache attributes for 768 Kbyte - 1 Mbyte
// Assumes: classic wishbone slave, one answer one edge after the request
// Notes: routing decisions register one cycle after each request
`timescale 1ns/1ps

// Behaviour
// - thirteen segments in 768K..1M controlled by seven attribute registers
// - read enable set sends host reads to memory, else to pci
// - write enable set sends host writes to memory, else to pci
// - cache enable gives l1 cacheability with read enable, code reads only without write enable
// - read-only segment host writes skip dram and l2, go to pci
// - read-only segments never allocate into l2 cache
// - write-only segment reads go to pci, writes serviced by memory
// - disabled segment sends every host read and write to pci
// - read/write segment serviced by memory for host and pci masters
// - nibble layout: read bit 0/4, write 1/5, cache 2/6, reserved 3/7
// - pci master write claimed only when segment is writeable
// - pci master read claimed only when segment is readable
// - non-writeable write or non-readable read leaves devsel deasserted
// - pci accesses inside an enabled memory hole are never claimed
// - attribute registers at 59h..5fh, read/write, reset to 00h
// - c0000..dffff split into eight 16 Kbyte segments
// - e0000..effff split into four 16 Kbyte segments
// - f0000..fffff is one segment, upper nibble of first register
// - a0000..bffff always goes to pci, never cacheable
module segment_attribute_map #(
  parameter logic [31:0] HOLE_BASE = 32'h00f00000,
  parameter logic [31:0] HOLE_LIMIT = 32'h00ffffff
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [segment_map_pkg::WB_ADR_W-1:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire segment_map_pkg::host_req_s host_req,
  output segment_map_pkg::host_route_s host_route,
  input wire segment_map_pkg::pci_req_s pci_req,
  output segment_map_pkg::pci_ans_s pci_ans
);

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  logic [7:0] segment_attribute_map [segment_map_pkg::ATTR_COUNT];
  logic [7:0] hole_ctrl;
  logic hole_enable;
  logic wb_hit;
  logic [7:0] reg_idx;
  logic attr_sel;
  logic [2:0] attr_idx;
  logic [31:0] next_dat;
  logic [2:0] host_attr;
  logic host_video;
  logic [2:0] pci_attr;
  logic pci_video;
  logic pci_in_hole;
  logic wr_strobe;

  assign reg_idx = wb_adr_i[segment_map_pkg::WB_ADR_W-1:2];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign attr_sel = (reg_idx >= segment_map_pkg::IDX_ATTR_FIRST)
                    && (reg_idx <= segment_map_pkg::IDX_ATTR_LAST);
  assign attr_idx = 3'(reg_idx - segment_map_pkg::IDX_ATTR_FIRST);
  assign hole_enable = hole_ctrl[segment_map_pkg::HOLE_EN_BIT];
  assign wr_strobe = wb_hit && wb_we_i && wb_sel_i[0];

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  // --------------------------------------------------------------
  // segment state codes
  // --------------------------------------------------------------
  // coarse regions of the low megabyte
  typedef enum logic [4:0] {
    REGION_DOS = 5'h01,
    REGION_VIDEO = 5'h02,
    REGION_TABLE = 5'h04,
    REGION_SYS_BIOS = 5'h08,
    REGION_EXTENDED = 5'h10
  } region_e;

  // read/write state of one segment
  typedef enum logic [3:0] {
    RW_DISABLED = 4'h1,
    RW_READ_ONLY = 4'h2,
    RW_WRITE_ONLY = 4'h4,
    RW_READ_WRITE = 4'h8
  } rw_state_e;

  function automatic region_e region_of(input logic [31:0] addr);
    if (addr < segment_map_pkg::VIDEO_BASE) begin
      region_of = REGION_DOS;
    end else if (addr < segment_map_pkg::EXP_BASE) begin
      region_of = REGION_VIDEO;
    end else if (addr < segment_map_pkg::BIOS_BASE) begin
      region_of = REGION_TABLE;
    end else if (addr < segment_map_pkg::EXT_BASE) begin
      region_of = REGION_SYS_BIOS;
    end else begin
      region_of = REGION_EXTENDED;
    end
  endfunction

  function automatic rw_state_e rw_state(input logic [2:0] attr);
    case ({attr[segment_map_pkg::BIT_WRITE_EN], attr[segment_map_pkg::BIT_READ_EN]})
      2'h1: begin
        rw_state = RW_READ_ONLY;
      end
      2'h2: begin
        rw_state = RW_WRITE_ONLY;
      end
      2'h3: begin
        rw_state = RW_READ_WRITE;
      end
      default: begin
        rw_state = RW_DISABLED;
      end
    endcase
  endfunction

  // --------------------------------------------------------------
  // attribute lookup
  // --------------------------------------------------------------
  // 16 Kbyte segment nibble, c0000 upward
  function automatic logic [3:0] table_nibble(
    input logic [31:0] addr,
    input logic [7:0] map [segment_map_pkg::ATTR_COUNT]
  );
    logic [5:0] granule;
    logic [3:0] seg;
    logic [7:0] regv;
    granule = addr[segment_map_pkg::GRANULE_LSB +: $bits(granule)];
    seg = 4'(granule - segment_map_pkg::GRANULE_EXP_FIRST);
    regv = map[3'(seg[3:1]) + 3'h1];
    table_nibble = seg[0] ? regv[segment_map_pkg::NIBBLE_W +: segment_map_pkg::NIBBLE_W]
                          : regv[0 +: segment_map_pkg::NIBBLE_W];
  endfunction

  // returns {cache, write, read} for an address
  function automatic logic [2:0] segment_attr(
    input logic [31:0] addr,
    input logic [7:0] map [segment_map_pkg::ATTR_COUNT]
  );
    logic [3:0] nib;
    nib = 4'h0;
    case (region_of(addr))
      REGION_VIDEO: begin
        // video area ignores every attribute bit
        segment_attr = segment_map_pkg::ATTR_NONE;
      end
      REGION_TABLE: begin
        nib = table_nibble(addr, map);
        segment_attr = nib[2:0];
      end
      REGION_SYS_BIOS: begin
        // bios uses upper nibble of first register
        nib = map[0][segment_map_pkg::NIBBLE_W +: segment_map_pkg::NIBBLE_W];
        segment_attr = nib[2:0];
      end
      default: begin
        // dos area and extended memory always fully enabled
        segment_attr = segment_map_pkg::ATTR_ALL;
      end
    endcase
  endfunction

  function automatic logic is_video(input logic [31:0] addr);
    is_video = (region_of(addr) == REGION_VIDEO);
  endfunction

  // thirteen nibbles, bits 0/1/2 used, bit 3 reserved
  assign host_attr = segment_attr(host_req.addr, segment_attribute_map);
  assign pci_attr = segment_attr(pci_req.addr, segment_attribute_map);
  assign host_video = is_video(host_req.addr);
  assign pci_video = is_video(pci_req.addr);
  assign pci_in_hole = hole_enable && (pci_req.addr >= HOLE_BASE)
                       && (pci_req.addr <= HOLE_LIMIT);

  // --------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------
  // attribute registers, reset 00h
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < segment_map_pkg::ATTR_COUNT; i++) begin
        segment_attribute_map[i] <= segment_map_pkg::ATTR_RESET;
      end
    end else if (wr_strobe && attr_sel) begin
      segment_attribute_map[attr_idx] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hole_ctrl <= segment_map_pkg::HOLE_CTRL_RESET;
    end else if (wr_strobe && reg_idx == segment_map_pkg::IDX_HOLE_CTRL) begin
      hole_ctrl <= {7'h00, wb_dat_i[segment_map_pkg::HOLE_EN_BIT]};
    end
  end

  // --------------------------------------------------------------
  // register reads and ack
  // --------------------------------------------------------------
  // live route flags for software, host valid in bit 0
  function automatic logic [31:0] status_word(
    input segment_map_pkg::host_route_s route,
    input segment_map_pkg::pci_ans_s ans
  );
    status_word = {26'h0000000, ans.claim, route.l2_allocate, route.l1_cacheable,
                   route.to_pci, route.to_memory, route.valid};
  endfunction

  always_comb begin
    next_dat = 32'h00000000;
    if (attr_sel) begin
      next_dat = {24'h000000, segment_attribute_map[attr_idx]};
    end else if (reg_idx == segment_map_pkg::IDX_HOLE_CTRL) begin
      next_dat = {24'h000000, hole_ctrl};
    end else if (reg_idx == segment_map_pkg::IDX_ROUTE_STATUS) begin
      next_dat = status_word(host_route, pci_ans);
    end
  end

  // unmapped indexes answer with zero data
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // --------------------------------------------------------------
  // host routing
  // --------------------------------------------------------------
  // route of one host cycle from its segment state
  function automatic segment_map_pkg::host_route_s host_decide(
    input segment_map_pkg::host_req_s req,
    input logic [2:0] attr,
    input logic video
  );
    logic ce_en;
    ce_en = attr[segment_map_pkg::BIT_CACHE_EN];
    host_decide = '0;
    host_decide.valid = 1'b1;
    if (video) begin
      host_decide.to_pci = 1'b1;
    end else begin
      case (rw_state(attr))
        RW_READ_ONLY: begin
          // writes skip dram and l2, go to pci
          host_decide.to_memory = !req.write;
          // l1 for code reads only, never l2
          host_decide.l1_cacheable = ce_en && req.code && !req.write;
        end
        RW_WRITE_ONLY: begin
          // reads to pci, writes to memory
          host_decide.to_memory = req.write;
        end
        RW_READ_WRITE: begin
          // memory services both directions, l2 when cache enabled
          host_decide.to_memory = 1'b1;
          host_decide.l1_cacheable = ce_en;
          host_decide.l2_allocate = ce_en;
        end
        default: begin
          host_decide.to_memory = 1'b0;
        end
      endcase
      host_decide.to_pci = !host_decide.to_memory;
    end
  endfunction

  // fields hold until the next request, valid pulses
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      host_route <= '0;
    end else if (host_req.valid) begin
      host_route <= host_decide(host_req, host_attr, host_video);
    end else begin
      host_route.valid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // pci master claim
  // --------------------------------------------------------------
  // devsel decision for one pci master access
  function automatic logic pci_claims(
    input segment_map_pkg::pci_req_s req,
    input logic [2:0] attr,
    input logic blocked
  );
    if (!req.valid || blocked) begin
      pci_claims = 1'b0;
    end else begin
      case (rw_state(attr))
        RW_READ_WRITE: begin
          pci_claims = 1'b1;
        end
        RW_READ_ONLY: begin
          pci_claims = !req.write;
        end
        RW_WRITE_ONLY: begin
          pci_claims = req.write;
        end
        default: begin
          pci_claims = 1'b0;
        end
      endcase
    end
  endfunction

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pci_ans <= '0;
    end else begin
      pci_ans.valid <= pci_req.valid;
      // hole and video range never claimed
      pci_ans.claim <= pci_claims(pci_req, pci_attr, pci_video || pci_in_hole);
    end
  end

endmodule

// ==== testbench/segment_attribute_map_assertions.sv ====
// Purpose: port checks for the segment map
// Assumes: one-cycle answers
// Notes: bound below
`timescale 1ns/1ps
module segment_attribute_map_assertions (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire segment_map_pkg::host_req_s host_req,
  input wire segment_map_pkg::host_route_s host_route,
  input wire segment_map_pkg::pci_req_s pci_req,
  input wire segment_map_pkg::pci_ans_s pci_ans
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  chk_ack_timing: assert property (s_take |=> s_pulse)
    else $error("late or long ack");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_host_answer: assert property (host_req.valid |=> host_route.valid
    && (host_route.to_memory != host_route.to_pci)) else $error("bad host route");
  chk_host_quiet: assert property (!host_req.valid |=> !host_route.valid)
    else $error("stray host route");
  chk_video_pci: assert property (
    host_req.valid && host_req.addr >= segment_map_pkg::VIDEO_BASE
    && host_req.addr < segment_map_pkg::EXP_BASE
    |=> host_route.to_pci && !host_route.l1_cacheable) else $error("video not to pci");
  chk_pci_no_l2: assert property (host_route.valid && host_route.to_pci
    |-> !host_route.l2_allocate) else $error("pci route allocates l2");
  chk_l1_memory: assert property (host_route.valid && host_route.l1_cacheable
    |-> host_route.to_memory) else $error("l1 cacheable off memory");
  chk_pci_answer: assert property (pci_req.valid |=> pci_ans.valid)
    else $error("pci answer missing");
  chk_claim_alone: assert property (pci_ans.claim |-> pci_ans.valid)
    else $error("claim without valid");
endmodule
bind segment_attribute_map segment_attribute_map_assertions u_chk (.mclk(mclk),
  .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .host_req(host_req), .host_route(host_route), .pci_req(pci_req), .pci_ans(pci_ans));

// ==== testbench/segment_map_requester.sv ====
// Purpose: host and pci master stand-in
// Assumes: bench checks the answers
// Notes: idle fields are scrambled
`timescale 1ns/1ps
module segment_map_requester (
  input wire logic mclk,
  output segment_map_pkg::host_req_s host_req,
  output segment_map_pkg::pci_req_s pci_req
);
  initial begin
    host_req = '0;
    pci_req = '0;
  end
  task automatic issue(input logic p, input logic w, input logic cd, input logic [31:0] ad);
    @(posedge mclk);
    if (p) begin
      pci_req <= '{1'b1, w, ad};
    end else begin
      host_req <= '{1'b1, w, cd, ad};
    end
    @(posedge mclk);
    host_req <= '{1'b0, ~w, ~cd, ~ad};
    pci_req <= '{1'b0, ~w, ~ad};
  endtask
endmodule

// ==== testbench/segment_attribute_map_tb.sv ====
// Purpose: self-checking bench for the segment map
// Assumes: one-cycle answers
// Notes: every code walks every segment
`timescale 1ns/1ps
module segment_attribute_map_tb;
  logic mclk, resetn, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [7:0] r [7];
  logic [2:0] c;
  logic [31:0] dw, dr, rd, a;
  segment_map_pkg::host_req_s hq;
  segment_map_pkg::host_route_s hr;
  segment_map_pkg::pci_req_s pq;
  segment_map_pkg::pci_ans_s pa;
  int fails = 0, cmp_count = 0, cycles = 0;
  // cache enable only with read enable
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h3, 3'h7};
  segment_attribute_map DUT (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .host_req(hq), .host_route(hr), .pci_req(pq), .pci_ans(pa));
  segment_map_requester u_req (.mclk(mclk), .host_req(hq), .pci_req(pq));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dw <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic host(input logic w, input logic cd, input logic m, input logic l1,
      input logic l2);
    u_req.issue(1'b0, w, cd, a);
    #1;
    check("host route", {27'h0, 1'b1, m, ~m, l1, l2}, {27'h0, hr});
  endtask
  task automatic pci(input logic w, input logic cl);
    u_req.issue(1'b1, w, 1'b0, a);
    #1;
    check("pci claim", {30'h0, 1'b1, cl}, {30'h0, pa});
  endtask
  initial begin
    resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dw = 32'h0;
    a = 32'h0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, 8'h59 + 8'(i), 8'h00);
      check("attr reset", 32'h0, rd);
    end
    r[0] = 8'h0f;
    for (int k = 0; k < 6; k++) begin
      for (int s = 0; s < 13; s++) begin
        r[(s + 1) / 2][((s + 1) % 2) * 4 +: 4] = {1'b0, codes[(s + k) % 6]};
      end
      for (int i = 0; i < 7; i++) begin
        wb(1'b1, 8'h59 + 8'(i), r[i]);
        wb(1'b0, 8'h59 + 8'(i), 8'h00);
        check("attr readback", {24'h0, r[i]}, rd);
      end
      for (int s = 0; s < 13; s++) begin
        c = codes[(s + k) % 6];
        a = (s == 0) ? 32'h000ffffc : 32'h000c3ffc + 32'(s - 1) * 32'h4000;
        host(1'b0, 1'b0, c[0], &c, &c);
        host(1'b0, 1'b1, c[0], c[2] & c[0], &c);
        host(1'b1, 1'b0, c[1], &c, &c);
        pci(1'b0, c[0]);
        pci(1'b1, c[1]);
      end
      a = 32'h000bfffc;
      host(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    end
    a = 32'h0009fffc;
    host(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    a = 32'h00f00000;
    pci(1'b1, 1'b1);
    wb(1'b1, 8'h40, 8'h01);
    wb(1'b0, 8'h40, 8'h00);
    check("hole readback", 32'h1, rd);
    pci(1'b1, 1'b0);
    pci(1'b0, 1'b0);
    wb(1'b0, 8'h41, 8'h00);
    check("route status", 32'h1a, rd);
    wb(1'b1, 8'h70, 8'hff);
    wb(1'b0, 8'h70, 8'h00);
    check("unmapped read", 32'h0, rd);
    results();
  end
endmodule
